// ==== design/asr_pkg.sv ====
// Constants shared by the serial receiver status and wakeup block
package asr_pkg;
   // -----------------------------------------------------------------
   // Register byte offsets
   // -----------------------------------------------------------------
   localparam logic [7:0] CTRL1_OFS = 8'h00;
   localparam logic [7:0] CTRL2_OFS = 8'h04;
   localparam logic [7:0] CTRL3_OFS = 8'h08;
   localparam logic [7:0] STAT1_OFS = 8'h0C;
   localparam logic [7:0] DATA_OFS  = 8'h10;
   localparam logic [7:0] PDIR_OFS  = 8'h14;
   // -----------------------------------------------------------------
   // Field positions
   // -----------------------------------------------------------------
   localparam int C1_EN    = 0;
   localparam int C1_NINE  = 1;
   localparam int C1_WAKE  = 2;
   localparam int C1_ILSEL = 3;
   localparam int C1_PEN   = 4;
   localparam int C1_PODD  = 5;
   localparam int C2_RXEN  = 0;
   localparam int C2_SBY   = 1;
   localparam int C2_RFIE  = 2;
   localparam int C2_IDLE_IRQ_ENABLE  = 3;
   localparam int C3_OVERRUN_IRQ_ENABLE  = 0;
   localparam int C3_NOISE_IRQ_ENABLE  = 1;
   localparam int C3_FRAMING_IRQ_ENABLE  = 2;
   localparam int C3_PARITY_IRQ_ENABLE  = 3;
   localparam int C3_R8    = 4;
   localparam int S1_FULL  = 0;
   localparam int S1_IDLE  = 1;
   localparam int S1_OR    = 2;
   localparam int S1_NF    = 3;
   localparam int S1_FE    = 4;
   localparam int S1_PE    = 5;
   localparam int PD_RX    = 4;
   localparam int PD_TX    = 5;
   // -----------------------------------------------------------------
   // Reset values
   // -----------------------------------------------------------------
   localparam logic [5:0] CTRL1_RST = 6'h00;
   localparam logic [3:0] CTRL2_RST = 4'h0;
   localparam logic [3:0] CTRL3_RST = 4'h0;
   localparam logic [7:0] PDIR_RST  = 8'h00;
   // -----------------------------------------------------------------
   // Oversampling counts, in sampling ticks; stop indices in bit times
   // -----------------------------------------------------------------
   localparam logic [4:0] TICKS_PER_BIT = 5'd16;
   localparam logic [4:0] VERIFY_LAST   = 5'd7;
   localparam logic [4:0] SAMPLE_FIRST  = 5'd8;
   localparam logic [4:0] SAMPLE_LAST   = 5'd10;
   localparam logic [3:0] STOP_IDX_8    = 4'd9;
   localparam logic [3:0] STOP_IDX_9    = 4'd10;
   localparam logic [7:0] IDLE_TICKS_8  = 8'd160;
   localparam logic [7:0] IDLE_TICKS_9  = 8'd176;
   // Receiver sequencer
   typedef enum logic {RX_HUNT = 1'b0, RX_SHIFT = 1'b1} asr_rx_state_t;
endpackage

// ==== design/asr_receiver.sv ====
// Receive status, wakeup, error and pin override logic with APB registers
`timescale 1ns/100ps
`default_nettype none
// How it works
// - Stop bit sampling to zero sets the framing error flag.
// - A break character sets the framing error flag too.
// - Framing error sets in the same cycle as receive full.
// - One stop sample off gives noise; two or more give framing error.
// - Sampling counter restarts on each valid falling edge in a data bit outside the sample window.
// - Stop sampled at nine or ten bit times plus ten ticks.
// - Standby bit set suppresses all receiver interrupt requests.
// - Address mark wakeup: msb of one clears standby and sets full.
// - Idle wakeup: idle clears standby, sets neither idle nor full.
// - Idle select chooses where the count of ones begins.
// - Idle select one counts after stop, zero after start; resets zero.
// - Standby set on an already idle line may wake at once.
// - Full flag sets on transfer to data register; gated receive request.
// - Idle flag after 10 or 11 ones; gated by idle enable.
// - Overrun keeps old character, drops new; gated error request.
// - Noise on start, data or stop sets noise flag; gated request.
// - Framing error requests only with its enable set.
// - Parity failure sets parity flag; gated error request.
// - Module runs in wait mode; enabled requests stay live.
// - Stop mode halts, keeps registers, drops character in progress.
// - Enabled module forces the transmit pin to output.
// - Enabled module forces the receive pin to input.
module asr_receiver
(
   input  wire logic        mclk,
   input  wire logic        resetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        oversample_tick,
   input  wire logic        rxd_in,
   input  wire logic        stop_mode,
   output logic             rx_irq,
   output logic             err_irq,
   output logic             txd_oe,
   output logic             rxd_oe
);
   import asr_pkg::*;

   // -----------------------------------------------------------------
   // Declarations
   // -----------------------------------------------------------------
   logic [5:0]    ctrl1_reg;
   logic [3:0]    ctrl2_reg;
   logic [3:0]    ctrl3_reg;
   logic [5:0]    stat1_reg;
   logic [7:0]    pdir_reg;
   logic [7:0]    rdata_reg;
   logic          r8_reg;
   logic          stat_seen_reg;
   asr_rx_state_t state_reg;
   logic [4:0]    rt_reg;
   logic [3:0]    bit_reg;
   logic [2:0]    hist_reg;
   logic [1:0]    samp_reg;
   logic [8:0]    shift_reg;
   logic          last_bit_reg;
   logic          noise_reg;
   logic [7:0]    ones_reg;
   logic          idle_armed_reg;
   logic          setup;
   logic          acc;
   logic          wr;
   logic          rd_data;
   logic          active;
   logic          tick;
   logic          maj;
   logic          diff;
   logic [3:0]    stop_idx;
   logic [7:0]    idle_lim;
   logic          at_stop;
   logic          done;
   logic          idle_hit;
   logic          msb;
   logic          par_err;
   logic          resync;
   logic          wake_addr;
   logic          wake_idle;
   logic          load;
   logic          clr_flags;

   // -----------------------------------------------------------------
   // Bus decode
   // -----------------------------------------------------------------
   // Zero wait states: pready is raised from the setup cycle
   assign setup   = psel & ~penable;
   assign acc     = psel & penable & pready;
   assign wr      = acc & pwrite;
   assign rd_data = acc & ~pwrite & (paddr == DATA_OFS);

   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
      begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end
      else
      begin
         pready  <= setup;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
         if (setup)
         begin
            case (paddr)
               CTRL1_OFS: prdata <= {26'h0, ctrl1_reg};
               CTRL2_OFS: prdata <= {28'h0, ctrl2_reg};
               CTRL3_OFS: prdata <= {27'h0, r8_reg, ctrl3_reg};
               STAT1_OFS: prdata <= {26'h0, stat1_reg};
               DATA_OFS:  prdata <= {24'h0, rdata_reg};
               PDIR_OFS:  prdata <= {24'h0, pdir_reg};
               default:   pslverr <= 1'b1;
            endcase
         end
      end
   end

   // -----------------------------------------------------------------
   // Control registers
   // -----------------------------------------------------------------
   // Registers only hold in stop mode; nothing here needs the clock gated
   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
      begin
         ctrl1_reg <= CTRL1_RST;
         ctrl3_reg <= CTRL3_RST;
         pdir_reg  <= PDIR_RST;
      end
      else if (wr)
      begin
         if (paddr == CTRL1_OFS)
            ctrl1_reg <= pwdata[5:0];
         if (paddr == CTRL3_OFS)
            ctrl3_reg <= pwdata[3:0];
         if (paddr == PDIR_OFS)
            pdir_reg <= pwdata[7:0];
      end
   end

   // Standby bit: software sets it, a wake condition clears it
   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
         ctrl2_reg <= CTRL2_RST;
      else
      begin
         if (wr && paddr == CTRL2_OFS)
            ctrl2_reg <= pwdata[3:0];
         if (wake_addr || wake_idle)
            ctrl2_reg[C2_SBY] <= 1'b0;
      end
   end

   // -----------------------------------------------------------------
   // Receive sampling
   // -----------------------------------------------------------------
   // Stop mode freezes the tick, so a character in flight is abandoned
   assign active   = ctrl1_reg[C1_EN] & ctrl2_reg[C2_RXEN] & ~stop_mode;
   assign tick     = active & oversample_tick;
   assign maj      = (samp_reg[0] & samp_reg[1]) | (samp_reg[0] & rxd_in)
                   | (samp_reg[1] & rxd_in);
   assign diff     = (samp_reg[0] != samp_reg[1]) | (samp_reg[1] != rxd_in);
   assign stop_idx = ctrl1_reg[C1_NINE] ? STOP_IDX_9 : STOP_IDX_8;
   assign at_stop  = (bit_reg == stop_idx);
   assign done     = tick & (state_reg == RX_SHIFT) & at_stop
                   & (rt_reg == SAMPLE_LAST);
   // Valid falling edge after a sampled one, outside the sample window;
   // late edges (slow sender) land early in the next bit, so both ends count
   assign resync   = (state_reg == RX_SHIFT) & ~at_stop & (bit_reg != 4'd0)
                   & last_bit_reg & hist_reg[0] & ~rxd_in
                   & ((rt_reg > SAMPLE_LAST) | (rt_reg < SAMPLE_FIRST));

   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
         hist_reg <= 3'b000;
      else if (tick)
         hist_reg <= {hist_reg[1:0], rxd_in};
      else if (!active)
         hist_reg <= 3'b000;
   end

   // Sequencer: start hunt, then bit counting at sixteen ticks a bit
   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
      begin
         state_reg <= RX_HUNT;
         rt_reg    <= 5'd0;
         bit_reg   <= 4'd0;
      end
      else if (!active)
      begin
         state_reg <= RX_HUNT;
         rt_reg    <= 5'd0;
         bit_reg   <= 4'd0;
      end
      else if (tick)
      begin
         case (state_reg)
            RX_HUNT:
            begin
               if (hist_reg == 3'b111 && !rxd_in)
               begin
                  state_reg <= RX_SHIFT;
                  rt_reg    <= 5'd1;
                  bit_reg   <= 4'd0;
               end
            end
            RX_SHIFT:
            begin
               if (done)
                  state_reg <= RX_HUNT;
               else if (bit_reg == 4'd0 && rt_reg == VERIFY_LAST
                        && (samp_reg[0] + samp_reg[1] + rxd_in) > 2'd1)
                  state_reg <= RX_HUNT;           // False start
               else if (resync)
               begin
                  rt_reg  <= 5'd1;
                  if (rt_reg > SAMPLE_LAST)
                     bit_reg <= bit_reg + 4'd1;
               end
               else if (rt_reg == TICKS_PER_BIT)
               begin
                  rt_reg  <= 5'd1;
                  bit_reg <= bit_reg + 4'd1;
               end
               else
                  rt_reg <= rt_reg + 5'd1;
            end
            default:
               state_reg <= RX_HUNT;
         endcase
      end
   end

   // Samples, noise accumulation and shift register
   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
      begin
         samp_reg     <= 2'b00;
         shift_reg    <= 9'h000;
         last_bit_reg <= 1'b0;
         noise_reg    <= 1'b0;
      end
      else if (tick && state_reg == RX_HUNT)
         noise_reg <= 1'b0;
      else if (tick)
      begin
         if (bit_reg == 4'd0 && (rt_reg == 5'd3 || rt_reg == 5'd5))
            samp_reg <= {samp_reg[0], rxd_in};
         if (rt_reg == SAMPLE_FIRST || rt_reg == 5'd9)
            samp_reg <= {samp_reg[0], rxd_in};
         if ((bit_reg == 4'd0 && rt_reg == VERIFY_LAST) || rt_reg == SAMPLE_LAST)
         begin
            if (diff || (bit_reg == 4'd0 && rt_reg == SAMPLE_LAST && maj))
               noise_reg <= 1'b1;
         end
         if (rt_reg == SAMPLE_LAST)
         begin
            last_bit_reg <= maj;
            if (bit_reg != 4'd0 && !at_stop)
               shift_reg[bit_reg - 4'd1] <= maj;
         end
      end
   end

   // -----------------------------------------------------------------
   // Character completion and status flags
   // -----------------------------------------------------------------
   assign msb     = ctrl1_reg[C1_NINE] ? shift_reg[8] : shift_reg[7];
   assign par_err = ctrl1_reg[C1_PEN] & ((ctrl1_reg[C1_NINE] ? ^shift_reg
                   : ^shift_reg[7:0]) != ctrl1_reg[C1_PODD]);
   assign wake_addr = done & ctrl2_reg[C2_SBY] & ctrl1_reg[C1_WAKE] & msb;
   assign idle_lim  = ctrl1_reg[C1_NINE] ? IDLE_TICKS_9 : IDLE_TICKS_8;
   assign idle_hit  = (ones_reg == idle_lim);
   // Level test, so a line already idle wakes at once
   assign wake_idle = ctrl2_reg[C2_SBY] & ~ctrl1_reg[C1_WAKE] & idle_hit
                    & active;
   assign load      = done & (~ctrl2_reg[C2_SBY] | wake_addr);
   assign clr_flags = rd_data & stat_seen_reg;

   // Data register keeps the old character on overrun
   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
      begin
         rdata_reg <= 8'h00;
         r8_reg    <= 1'b0;
      end
      else if (load && !(stat1_reg[S1_FULL] && !clr_flags))
      begin
         rdata_reg <= shift_reg[7:0];
         r8_reg    <= msb;
      end
   end

   // Status read arms the clear, data read completes it
   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
         stat_seen_reg <= 1'b0;
      else if (acc && !pwrite)
         stat_seen_reg <= (paddr == STAT1_OFS);
   end

   // Set wins over the clear in the same cycle
   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
         stat1_reg <= 6'h00;
      else
      begin
         if (clr_flags)
            stat1_reg <= 6'h00;
         if (load)
         begin
            if (stat1_reg[S1_FULL] && !clr_flags)
               stat1_reg[S1_OR] <= 1'b1;
            else
            begin
               stat1_reg[S1_FULL] <= 1'b1;
               stat1_reg[S1_FE]   <= ~maj;
               stat1_reg[S1_NF]   <= noise_reg | diff;
               stat1_reg[S1_PE]   <= par_err;
            end
         end
         if (idle_hit && idle_armed_reg && !ctrl2_reg[C2_SBY])
            stat1_reg[S1_IDLE] <= 1'b1;
      end
   end

   // Count ticks of ones; select decides whether a character body counts
   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
      begin
         ones_reg       <= 8'd0;
         idle_armed_reg <= 1'b0;
      end
      else
      begin
         if (tick)
         begin
            if (!rxd_in)
               ones_reg <= 8'd0;
            else if (state_reg == RX_SHIFT && ctrl1_reg[C1_ILSEL])
               ones_reg <= 8'd0;
            else if (state_reg == RX_SHIFT && bit_reg == 4'd0)
               ones_reg <= 8'd0;
            else if (!idle_hit)
               ones_reg <= ones_reg + 8'd1;
         end
         if (done)
            idle_armed_reg <= 1'b1;
         else if (idle_hit)
            idle_armed_reg <= 1'b0;
      end
   end

   // -----------------------------------------------------------------
   // Interrupt requests and pin direction
   // -----------------------------------------------------------------
   // Requests stay live in wait mode so they can wake the core
   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
      begin
         rx_irq  <= 1'b0;
         err_irq <= 1'b0;
      end
      else
      begin
         rx_irq  <= ~ctrl2_reg[C2_SBY]
                  & ((stat1_reg[S1_FULL] & ctrl2_reg[C2_RFIE])
                  | (stat1_reg[S1_IDLE] & ctrl2_reg[C2_IDLE_IRQ_ENABLE]));
         err_irq <= ~ctrl2_reg[C2_SBY]
                  & ((stat1_reg[S1_OR] & ctrl3_reg[C3_OVERRUN_IRQ_ENABLE])
                  | (stat1_reg[S1_NF] & ctrl3_reg[C3_NOISE_IRQ_ENABLE])
                  | (stat1_reg[S1_FE] & ctrl3_reg[C3_FRAMING_IRQ_ENABLE])
                  | (stat1_reg[S1_PE] & ctrl3_reg[C3_PARITY_IRQ_ENABLE]));
      end
   end

   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
      begin
         txd_oe <= 1'b0;
         rxd_oe <= 1'b0;
      end
      else
      begin
         txd_oe <= ctrl1_reg[C1_EN] | pdir_reg[PD_TX];
         rxd_oe <= ~ctrl1_reg[C1_EN] & pdir_reg[PD_RX];
      end
   end
endmodule
`default_nettype wire

// ==== verif/asr_receiver_assertions.sv ====
// Checker for bus timing, pin override and request gating
`timescale 1ns/100ps
`default_nettype none
module asr_receiver_chk
(
   input wire logic        mclk,
   input wire logic        resetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        oversample_tick,
   input wire logic        rxd_in,
   input wire logic        stop_mode,
   input wire logic        rx_irq,
   input wire logic        err_irq,
   input wire logic        txd_oe,
   input wire logic        rxd_oe
);
   import asr_pkg::*;
   logic       en_reg;
   logic [1:0] rie_reg;
   logic [3:0] eie_reg;
   // Mirror of the enables, updated where a write lands
   always_ff @(posedge mclk or negedge resetn)
      if (!resetn)
      begin
         en_reg  <= 1'h0;
         rie_reg <= 2'h0;
         eie_reg <= 4'h0;
      end
      else if (psel && penable && pready && pwrite)
      begin
         if (paddr == CTRL1_OFS)
            en_reg <= pwdata[C1_EN];
         if (paddr == CTRL2_OFS)
            rie_reg <= pwdata[C2_IDLE_IRQ_ENABLE:C2_RFIE];
         if (paddr == CTRL3_OFS)
            eie_reg <= pwdata[C3_PARITY_IRQ_ENABLE:C3_OVERRUN_IRQ_ENABLE];
      end
   // -------------------------------------------------
   // Properties
   // -------------------------------------------------
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!resetn);
   sequence setup_s;
      psel && !penable;
   endsequence
   sequence done_s;
      psel && penable && pready;
   endsequence
   // Zero wait states, answer stands one cycle
   ready_next_a: assert property (setup_s |=> pready) else $error("pready late");
   ready_once_a: assert property (pready |=> !pready) else $error("pready held");
   slverr_map_a: assert property (done_s ##0 paddr[1:0] == 2'h0
      |-> pslverr == (paddr > PDIR_OFS)) else $error("pslverr wrong");
   rdata_idle_a: assert property (!penable |-> prdata == 32'h0) else $error("prdata set");
   // One cycle of slack for the registered pin enables
   tx_out_a:
      assert property (en_reg && $past(en_reg) |-> txd_oe) else $error("tx not output");
   rx_in_a:
      assert property (en_reg && $past(en_reg) |-> !rxd_oe) else $error("rx not input");
   rx_gate_a:
      assert property (rie_reg == 2'h0 && $past(rie_reg) == 2'h0 |-> !rx_irq)
      else $error("rx request ungated");
   err_gate_a:
      assert property (eie_reg == 4'h0 && $past(eie_reg) == 4'h0 |-> !err_irq)
      else $error("error request ungated");
   // Flags already in flight may land just after the halt
   stop_hold_a:
      assert property (stop_mode && $past(stop_mode, 3) && !$past(psel) && !$past(psel, 2)
      |-> !$rose(rx_irq) && !$rose(err_irq)) else $error("request while halted");
endmodule
bind asr_receiver asr_receiver_chk u_chk
(
   .mclk(mclk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .oversample_tick(oversample_tick), .rxd_in(rxd_in), .stop_mode(stop_mode),
   .rx_irq(rx_irq), .err_irq(err_irq), .txd_oe(txd_oe), .rxd_oe(rxd_oe)
);
`default_nettype wire

// ==== verif/asr_receiver_tb.sv ====
// Self-checking bench for the receiver status and wakeup block
`timescale 1ns/100ps
`default_nettype none
module asr_receiver_tb;
   import asr_pkg::*;
   logic        mclk;
   logic        resetn;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [7:0]  paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        tick;
   logic        rxd;
   logic        stop_mode;
   logic        rx_irq;
   logic        err_irq;
   logic        txd_oe;
   logic        rxd_oe;
   logic [31:0] rd;
   logic        se;
   logic        fe;
   logic        nf;
   int          num_errors;
   int          checked;
   asr_receiver uut
   (
      .mclk(mclk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .oversample_tick(tick), .rxd_in(rxd), .stop_mode(stop_mode),
      .rx_irq(rx_irq), .err_irq(err_irq), .txd_oe(txd_oe), .rxd_oe(rxd_oe)
   );
   asr_tx_model rtx
   (
      .mclk(mclk),
      .tick(tick),
      .line(rxd)
   );
   // 25 MHz clock
   initial
   begin
      mclk = 1'h0;
      forever #20 mclk = ~mclk;
   end
   // Oversampling tick, one cycle in four keeps frames short
   initial
   begin
      tick = 1'h0;
      forever
      begin
         repeat (3) @(posedge mclk);
         tick <= 1'h1;
         @(posedge mclk);
         tick <= 1'h0;
      end
   end
   // -------------------------------------------------
   // Bus and check tasks
   // -------------------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      begin
         checked++;
         if (got !== exp)
         begin
            num_errors++;
            $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
         end
      end
   endtask
   // APB transfer; waits for pready, bounded
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      begin
         n = 0;
         @(posedge mclk);
         psel    <= 1'h1;
         pwrite  <= w;
         paddr   <= a;
         pwdata  <= d;
         @(posedge mclk);
         penable <= 1'h1;
         @(posedge mclk);
         while (pready !== 1'h1 && n < 20)
         begin
            @(posedge mclk);
            n++;
         end
         chk({31'h0, pready}, 32'h1, "pready");
         rd = prdata;
         se = pslverr;
         psel    <= 1'h0;
         penable <= 1'h0;
      end
   endtask
   task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input string what);
      begin
         xfer(1'h0, a, 32'h0);
         chk(rd, exp, what);
      end
   endtask
   task automatic ichk(input logic e, input logic r);
      chk({30'h0, err_irq, rx_irq}, {30'h0, e, r}, "irq");
   endtask
   task automatic wt(input int n);
      repeat (n) @(posedge mclk iff tick);
   endtask
   task automatic finish_test;
      begin
         $display("Mismatches %0d, checks %0d", num_errors, checked);
         if (num_errors == 0 && checked > 0)
            $display("Run complete: PASS");
         else
            $display("Run complete: FAIL");
         $finish;
      end
   endtask
   // Watchdog, several times the expected run length
   initial
   begin
      #(40 * 80000);
      num_errors++;
      finish_test;
   end
   // Main sequence
   initial
   begin
      resetn = 1'h0;
      psel = 1'h0;
      penable = 1'h0;
      pwrite = 1'h0;
      paddr = 8'h00;
      pwdata = 32'h0;
      stop_mode = 1'h0;
      num_errors = 0;
      checked = 0;
      repeat (3) @(posedge mclk);
      resetn <= 1'h1;
      for (int i = 0; i < 4; i++)
         rchk(8'(i * 4), 32'h0, "reset");
      xfer(1'h0, 8'h20, 32'h0);
      chk({rd[30:0], se}, 32'h1, "unmapped");
      xfer(1'h1, PDIR_OFS, 32'h10);
      repeat (2) @(posedge mclk);
      chk({30'h0, txd_oe, rxd_oe}, 32'h1, "port dir");
      xfer(1'h1, CTRL1_OFS, 32'h1);
      repeat (2) @(posedge mclk);
      chk({30'h0, txd_oe, rxd_oe}, 32'h2, "override");
      xfer(1'h1, CTRL2_OFS, 32'h5);
      // Every stop sample pattern; pattern zero with zero data is a break
      for (int p = 0; p < 8; p++)
      begin
         xfer(1'h1, CTRL3_OFS, p[0] ? 32'h4 : 32'h2);
         rtx.send(p == 0 ? 9'h000 : 9'h03C, 8, 16, 3'(p));
         wt(3);
         fe = ($countones(3'(p)) < 2);
         nf = (p != 0 && p != 7);
         ichk(p[0] ? fe : nf, 1'h1);
         rchk(STAT1_OFS, {26'h0, 1'h0, fe, nf, 3'h1}, "stop");
         rchk(DATA_OFS, p == 0 ? 32'h0 : 32'h3C, "data");
      end
      // Even parity, good then bad
      xfer(1'h1, CTRL1_OFS, 32'h11);
      xfer(1'h1, CTRL3_OFS, 32'h8);
      for (int k = 0; k < 2; k++)
      begin
         rtx.send(k ? 9'h007 : 9'h003, 8, 16, 3'h7);
         wt(3);
         ichk(1'(k), 1'h1);
         rchk(STAT1_OFS, {26'h0, 1'(k), 5'h01}, "parity");
         xfer(1'h0, DATA_OFS, 32'h0);
      end
      // Overrun keeps the first character
      xfer(1'h1, CTRL1_OFS, 32'h1);
      xfer(1'h1, CTRL3_OFS, 32'h1);
      rtx.send(9'h011, 8, 16, 3'h7);
      rtx.send(9'h022, 8, 16, 3'h7);
      wt(3);
      ichk(1'h1, 1'h1);
      rchk(STAT1_OFS, 32'h5, "overrun");
      rchk(DATA_OFS, 32'h11, "kept");
      // Nine-bit character, ninth bit to r8
      xfer(1'h1, CTRL3_OFS, 32'h0);
      xfer(1'h1, CTRL1_OFS, 32'h3);
      rtx.send(9'h1A5, 9, 16, 3'h7);
      wt(3);
      rchk(STAT1_OFS, 32'h1, "nine");
      rchk(DATA_OFS, 32'hA5, "nine data");
      rchk(CTRL3_OFS, 32'h10, "r8");
      // Slow sender, only resync keeps the stop bit in reach
      xfer(1'h1, CTRL1_OFS, 32'h1);
      rtx.send(9'h055, 8, 18, 3'h7);
      wt(3);
      rchk(STAT1_OFS, 32'h1, "resync");
      rchk(DATA_OFS, 32'h55, "resync data");
      // Halt in mid character
      fork
         rtx.send(9'h0FF, 8, 16, 3'h7);
         begin
            wt(40);
            stop_mode <= 1'h1;
            wt(30);
            stop_mode <= 1'h0;
         end
      join
      wt(3);
      xfer(1'h0, STAT1_OFS, 32'h0);
      chk(rd & 32'h1, 32'h0, "halted char");
      rchk(CTRL1_OFS, 32'h1, "kept regs");
      // Idle count start after start bit, then after stop bit
      xfer(1'h1, CTRL2_OFS, 32'h9);
      for (int s = 0; s < 2; s++)
      begin
         xfer(1'h1, CTRL1_OFS, s ? 32'h9 : 32'h1);
         xfer(1'h0, STAT1_OFS, 32'h0);
         xfer(1'h0, DATA_OFS, 32'h0);
         rtx.send(9'h0FF, 8, 16, 3'h7);
         wt(40);
         rchk(STAT1_OFS, s ? 32'h1 : 32'h3, "idle start");
         rchk(DATA_OFS, 32'hFF, "idle data");
         wt(160);
         ichk(1'h0, 1'(s));
         rchk(STAT1_OFS, s ? 32'h2 : 32'h0, "idle late");
         xfer(1'h0, DATA_OFS, 32'h0);
      end
      // Idle wakeup on a line already idle
      xfer(1'h1, CTRL2_OFS, 32'hF);
      wt(2);
      rchk(CTRL2_OFS, 32'hD, "idle wake");
      rchk(STAT1_OFS, 32'h0, "wake flags");
      // Address mark wakeup, then back to standby on a mismatch
      xfer(1'h1, CTRL1_OFS, 32'h5);
      xfer(1'h1, CTRL2_OFS, 32'h7);
      rtx.send(9'h085, 8, 16, 3'h7);
      wt(3);
      ichk(1'h0, 1'h1);
      rchk(CTRL2_OFS, 32'h5, "mark wake");
      rchk(DATA_OFS, 32'h85, "address");
      if (rd[7:0] != 8'h81)
         xfer(1'h1, CTRL2_OFS, 32'h7);
      wt(2);
      ichk(1'h0, 1'h0);
      rchk(STAT1_OFS, 32'h1, "mark full");
      xfer(1'h0, DATA_OFS, 32'h0);
      rtx.send(9'h012, 8, 16, 3'h7);
      wt(3);
      ichk(1'h0, 1'h0);
      rchk(STAT1_OFS, 32'h0, "no mark");
      finish_test;
   end
endmodule
`default_nettype wire

// ==== verif/asr_tx_model.sv ====
// Remote serial transmitter that drives the receive line
`timescale 1ns/100ps
`default_nettype none
module asr_tx_model
(
   input  wire logic mclk,
   input  wire logic tick,
   output logic      line
);
   // Line idles high between frames
   initial
      line = 1'h1;
   // Hold a level for n ticks; changes land just after a tick
   task automatic hold(input logic v, input int n);
      begin
         line <= v;
         repeat (n) @(posedge mclk iff tick);
      end
   endtask
   // Start bit, LSB-first data, then a stop bit shaped at RT8..RT10
   task automatic send(input logic [8:0] d, input int nb, input int tpb,
                       input logic [2:0] sp);
      begin
         // Three idle ticks so the receiver has seen ones before the start
         hold(1'h1, 3);
         hold(1'h0, tpb);
         for (int i = 0; i < nb; i++)
            hold(d[i], tpb);
         hold(1'h1, 8);
         for (int i = 2; i >= 0; i--)
            hold(sp[i], 1);
         hold(1'h1, 5);
      end
   endtask
endmodule
`default_nettype wire
